// ---- verilog/clkgen_defs.svh ----
// constants for the two-wire control byte bank and clock gating
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH
// ----------------------------------------------------------------
// link addressing and read-back
// ----------------------------------------------------------------
`define ADDR_WR_BYTE   8'hd2
`define ADDR_RD_BYTE   8'hd3
`define RD_COUNT_BYTE  8'h06
`define IDLE_TX_BYTE   8'hff
// ----------------------------------------------------------------
// register offsets and count
// ----------------------------------------------------------------
`define NUM_REGS       6
`define REG_MISC       3'h0
`define REG_MEM_EN     3'h1
`define REG_PCI_EN     3'h2
`define REG_RSV_INV    3'h3
`define REG_RSV        3'h4
`define REG_SPARE      3'h5
// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define MISC_USB_BIT   1
`define MISC_DOT_BIT   2
`define MISC_SPREAD_BIT 3
`define RSV_INV_MASK   8'h70
// ----------------------------------------------------------------
// power-on default values
// ----------------------------------------------------------------
`define RST_MISC       8'h07
`define RST_MEM_EN     8'hff
`define RST_PCI_EN     8'hff
`define RST_RSV_INV    8'h00
`define RST_RSV        8'h00
`define RST_SPARE      8'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ   25000
`define LINK_MAX_KBPS  100
`define CLK_PER_BIT    (`CLK_FREQ_KHZ / `LINK_MAX_KBPS)
`endif

// ---- verilog/clkgen_pkg.sv ----
// types shared by the control byte bank and its clock gating
package clkgen_pkg;
   // ----------------------------------------------------------------
   // link state machine, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_SACK = 6'h04,
      ST_RX   = 6'h08,
      ST_TX   = 6'h10,
      ST_RACK = 6'h20
   } link_state_t;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic scl;
      logic sda;
   } link_pins_t;
   typedef struct packed {
      logic pci;
      logic mem;
      logic dot;
      logic usb;
   } clk_src_t;
   typedef logic [5:0][7:0] reg_file_t;
endpackage : clkgen_pkg

// ---- verilog/clock_gate_bank.sv ----
// glitch-free enable gating for a bank of clock outputs
`timescale 1ns/100ps
module clock_gate_bank #(
   parameter int N = 18
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [N-1:0] src_in,
   input  wire logic [N-1:0] en_in,
   output logic      [N-1:0] clk_out
);
   logic [N-1:0] en_q;
   logic [N-1:0] en_d;
   logic [N-1:0] out_q;
   logic [N-1:0] out_d;

   // ----------------------------------------------------------------
   // enable taken only in the low phase
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < N; i++) begin
         en_d[i] = src_in[i] ? en_q[i] : en_in[i];
      end
      out_d = src_in & en_q;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         en_q  <= '0;
         out_q <= '0;
      end else begin
         en_q  <= en_d;
         out_q <= out_d;
      end
   end

   assign clk_out = out_q;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   AST_GATE_HELD_LOW: assert property (
      ##1 ((clk_out & ~$past(en_q)) == '0))
      else $error("stopped clock output went high");
   AST_NO_RUNT: assert property (
      ##1 (((en_q ^ $past(en_q)) & $past(src_in)) == '0))
      else $error("enable changed while source was high");
endmodule : clock_gate_bank

// ---- verilog/clock_output_enable_regs.sv ----
// two-wire slave control byte bank driving gated clock outputs
`timescale 1ns/100ps
`include "clkgen_defs.svh"
module clock_output_enable_regs #(
   parameter int FS_W = 2
) (
   input  wire logic                   clk_in,
   input  wire logic                   rst_b_in,
   input  wire clkgen_pkg::link_pins_t link_in,
   output logic                        sda_out,
   output logic                        sda_oe_out,
   input  wire clkgen_pkg::clk_src_t   src_in,
   input  wire logic [FS_W-1:0]        freq_select_pin_in,
   output logic      [7:0]             pci_clock_out,
   output logic      [7:0]             mem_clock_out,
   output logic                        mem_free_clock_out,
   output logic                        dot_clock_out,
   output logic                        usb_clock_out,
   output logic                        spread_on_out,
   output logic      [FS_W-1:0]        fs_latched_out
);
   import clkgen_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   link_state_t     state_q;
   link_state_t     state_d;
   logic            scl_q;
   logic            sda_q;
   logic [3:0]      bit_q;
   logic [3:0]      bit_d;
   logic [7:0]      sh_q;
   logic [7:0]      sh_d;
   logic            rd_q;
   logic            rd_d;
   logic            ack_q;
   logic            ack_d;
   logic [3:0]      wcnt_q;
   logic [3:0]      wcnt_d;
   logic [3:0]      ridx_q;
   logic [3:0]      ridx_d;
   logic            oe_q;
   logic            oe_d;
   reg_file_t       regs_q;
   reg_file_t       regs_d;
   logic [FS_W-1:0] fs_q;
   logic [FS_W-1:0] fs_d;
   logic            fs_done_q;
   logic            free_q;
   logic            rise;
   logic            fall;
   logic            start;
   logic            stop;
   logic [7:0]      tx_next;
   logic [17:0]     gate_src;
   logic [17:0]     gate_en;
   logic [17:0]     gate_out;

   // ----------------------------------------------------------------
   // read-back byte for a transmit index (0 = byte count)
   // ----------------------------------------------------------------
   function automatic logic [7:0] rd_byte(input reg_file_t r, input logic [3:0] i);
      logic [2:0] k;
      k = 3'(i - 4'h1);
      if (i == 4'h0) begin
         rd_byte = `RD_COUNT_BYTE;
      end else if (i > 4'(`NUM_REGS)) begin
         rd_byte = `IDLE_TX_BYTE;
      end else if (k == `REG_RSV_INV) begin
         rd_byte = r[k] ^ `RSV_INV_MASK;
      end else begin
         rd_byte = r[k];
      end
   endfunction : rd_byte

   // ----------------------------------------------------------------
   // link events; pins arrive synchronous, one sample kept for edges
   // ----------------------------------------------------------------
   assign rise    = link_in.scl & ~scl_q;
   assign fall    = ~link_in.scl & scl_q;
   assign start   = scl_q & link_in.scl & sda_q & ~link_in.sda;
   assign stop    = scl_q & link_in.scl & ~sda_q & link_in.sda;
   assign tx_next = rd_byte(regs_q, ridx_q);

   // ----------------------------------------------------------------
   // link state machine and register loading
   // ----------------------------------------------------------------
   // every bit is seen on many clk_in edges at 100 kbit/s, so the
   // single-sample edge detect has ample margin
   always_comb begin
      state_d = state_q;
      bit_d   = bit_q;
      sh_d    = sh_q;
      rd_d    = rd_q;
      ack_d   = ack_q;
      wcnt_d  = wcnt_q;
      ridx_d  = ridx_q;
      oe_d    = oe_q;
      regs_d  = regs_q;
      if (stop) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (start) begin
         state_d = ST_ADDR;
         bit_d   = 4'h0;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_ADDR: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], link_in.sda};
                  bit_d = bit_q + 4'h1;
               end else if (fall && bit_q == 4'h8) begin
                  if (sh_q == `ADDR_WR_BYTE || sh_q == `ADDR_RD_BYTE) begin
                     state_d = ST_SACK;
                     oe_d    = 1'b1;
                     rd_d    = sh_q[0];
                     wcnt_d  = 4'h0;
                     ridx_d  = 4'h0;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_SACK: begin
               if (fall) begin
                  bit_d = 4'h0;
                  if (rd_q) begin
                     state_d = ST_TX;
                     sh_d    = tx_next;
                     oe_d    = ~tx_next[7];
                     ridx_d  = (ridx_q < 4'h7) ? ridx_q + 4'h1 : ridx_q;
                  end else begin
                     state_d = ST_RX;
                     oe_d    = 1'b0;
                  end
               end
            end
            ST_RX: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], link_in.sda};
                  bit_d = bit_q + 4'h1;
               end else if (fall && bit_q == 4'h8) begin
                  // command and count bytes are acknowledged, not stored
                  if (wcnt_q >= 4'h2 && wcnt_q < 4'(`NUM_REGS + 2)) begin
                     regs_d[3'(wcnt_q - 4'h2)] = sh_q;
                  end
                  wcnt_d  = (wcnt_q < 4'h8) ? wcnt_q + 4'h1 : wcnt_q;
                  state_d = ST_SACK;
                  oe_d    = 1'b1;
               end
            end
            ST_TX: begin
               if (rise) begin
                  bit_d = bit_q + 4'h1;
               end else if (fall) begin
                  if (bit_q == 4'h8) begin
                     state_d = ST_RACK;
                     oe_d    = 1'b0;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  if (link_in.sda) begin
                     state_d = ST_IDLE;
                  end else begin
                     ack_d = 1'b1;
                  end
               end else if (fall && ack_q) begin
                  ack_d   = 1'b0;
                  bit_d   = 4'h0;
                  state_d = ST_TX;
                  sh_d    = tx_next;
                  oe_d    = ~tx_next[7];
                  ridx_d  = (ridx_q < 4'h7) ? ridx_q + 4'h1 : ridx_q;
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // frequency-select capture after reset release
   // ----------------------------------------------------------------
   always_comb begin
      fs_d = fs_done_q ? fs_q : ~freq_select_pin_in;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_q   <= ST_IDLE;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         bit_q     <= 4'h0;
         sh_q      <= 8'h00;
         rd_q      <= 1'b0;
         ack_q     <= 1'b0;
         wcnt_q    <= 4'h0;
         ridx_q    <= 4'h0;
         oe_q      <= 1'b0;
         regs_q    <= {`RST_SPARE, `RST_RSV, `RST_RSV_INV,
                       `RST_PCI_EN, `RST_MEM_EN, `RST_MISC};
         fs_q      <= '0;
         fs_done_q <= 1'b0;
         free_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         scl_q     <= link_in.scl;
         sda_q     <= link_in.sda;
         bit_q     <= bit_d;
         sh_q      <= sh_d;
         rd_q      <= rd_d;
         ack_q     <= ack_d;
         wcnt_q    <= wcnt_d;
         ridx_q    <= ridx_d;
         oe_q      <= oe_d;
         regs_q    <= regs_d;
         fs_q      <= fs_d;
         fs_done_q <= 1'b1;
         free_q    <= src_in.mem;
      end
   end

   // ----------------------------------------------------------------
   // output gating
   // ----------------------------------------------------------------
   assign gate_src = {src_in.usb, src_in.dot, {8{src_in.mem}}, {8{src_in.pci}}};
   assign gate_en  = {regs_q[`REG_MISC][`MISC_USB_BIT],
                      regs_q[`REG_MISC][`MISC_DOT_BIT],
                      regs_q[`REG_MEM_EN], regs_q[`REG_PCI_EN]};

   clock_gate_bank #(
      .N(18)
   ) u_gate (
      .clk_in  (clk_in),
      .rst_b_in(rst_b_in),
      .src_in  (gate_src),
      .en_in   (gate_en),
      .clk_out (gate_out)
   );

   assign pci_clock_out      = gate_out[7:0];
   assign mem_clock_out      = gate_out[15:8];
   assign dot_clock_out      = gate_out[16];
   assign usb_clock_out      = gate_out[17];
   assign mem_free_clock_out = free_q;
   assign spread_on_out      = ~regs_q[`REG_MISC][`MISC_SPREAD_BIT];
   assign fs_latched_out     = fs_q;
   // open drain: the pin is only ever pulled low
   assign sda_out            = 1'b0;
   assign sda_oe_out         = oe_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_addr_done(logic [7:0] a);
      state_q == ST_ADDR && fall && bit_q == 4'h8 && sh_q == a && !start && !stop;
   endsequence
   sequence s_ack_drive;
      state_q == ST_SACK && sda_oe_out;
   endsequence

   AST_RD_ADDR_ACK: assert property (s_addr_done(`ADDR_RD_BYTE) |=> s_ack_drive)
      else $error("read address not acknowledged");
   AST_WR_ADDR_ACK: assert property (s_addr_done(`ADDR_WR_BYTE) |=> s_ack_drive ##0 !rd_q)
      else $error("write address not acknowledged");
   AST_COUNT_FIRST: assert property (
      (state_q == ST_SACK && rd_q && fall && !start && !stop)
      |=> state_q == ST_TX && sh_q == `RD_COUNT_BYTE && ridx_q == 4'h1)
      else $error("byte count not sent first");
   AST_READ_ORDER: assert property (
      (state_q == ST_RACK && ack_q && fall && !start && !stop && ridx_q < 4'h7)
      |=> ridx_q == $past(ridx_q) + 4'h1 && sh_q == rd_byte(regs_q, $past(ridx_q)))
      else $error("read bytes out of order");
   AST_SPREAD: assert property (
      spread_on_out != regs_q[`REG_MISC][`MISC_SPREAD_BIT])
      else $error("spread control polarity wrong");
   AST_INV_READ: assert property (
      rd_byte(regs_q, 4'h4) == (regs_q[`REG_RSV_INV] ^ `RSV_INV_MASK))
      else $error("inverting bits read back wrong");
   AST_FS_HOLD: assert property (
      fs_done_q ##1 fs_done_q |-> $stable(fs_q))
      else $error("latched select changed after power-up");
   AST_FREE_RUN: assert property (
      ##1 mem_free_clock_out == $past(src_in.mem))
      else $error("free-running memory clock not following source");
   AST_STOP_ENDS: assert property (
      stop |=> state_q == ST_IDLE ##1 $stable(regs_q) [*2])
      else $error("loading continued after stop");
endmodule : clock_output_enable_regs

// ---- tb/two_wire_host.sv ----
// two-wire host controller model for the control byte bank
`timescale 1ns/100ps
module two_wire_host (
   input  wire logic clk_in,
   input  wire logic dev_pull_in,
   output logic      scl_out,
   output logic      sda_out
);
   logic host_pull_q;
   int   half_cycles = 4;
   // pulled-up open drain: low while either party pulls
   assign sda_out = ~(host_pull_q | dev_pull_in);
   initial begin
      scl_out = 1'b1;
      host_pull_q = 1'b0;
   end
   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   // three halves per bit; 84 gives just under the 100 kbit/s limit
   task wait_half;
      repeat (half_cycles) @(negedge clk_in);
   endtask : wait_half
   task start_cond;
      host_pull_q = 1'b0;
      wait_half;
      scl_out = 1'b1;
      wait_half;
      host_pull_q = 1'b1;
      wait_half;
      scl_out = 1'b0;
      wait_half;
   endtask : start_cond
   task stop_cond;
      host_pull_q = 1'b1;
      wait_half;
      scl_out = 1'b1;
      wait_half;
      host_pull_q = 1'b0;
      wait_half;
   endtask : stop_cond
   // data set while scl low, sampled at the end of the high phase
   task pulse_bit(input logic drive_low, output logic seen);
      host_pull_q = drive_low;
      wait_half;
      scl_out = 1'b1;
      wait_half;
      seen = sda_out;
      scl_out = 1'b0;
      wait_half;
   endtask : pulse_bit
   task wr_byte(input logic [7:0] d, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         pulse_bit(~d[i], seen);
      end
      pulse_bit(1'b0, seen);
      ack = ~seen;
   endtask : wr_byte
   task rd_byte(output logic [7:0] d, input logic give_ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         pulse_bit(1'b0, d[i]);
      end
      pulse_bit(give_ack, seen);
   endtask : rd_byte
endmodule : two_wire_host

// ---- tb/clock_output_enable_regs_test.sv ----
// self-checking bench for the two-wire control byte bank
`timescale 1ns/100ps
`define CHECK_EQ(got, exp, what) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("mismatch at %0t: %s", $time, what); \
      end \
   end
module clock_output_enable_regs_test;
   import clkgen_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_b = 1'b0;
   logic [1:0]  fs_pins = 2'b01;
   logic [3:0]  src_cnt = 4'h0;
   logic        scl, sda_wire, sda_oe, sda_val, spread_on, free_clk, dot_clk, usb_clk;
   logic [7:0]  pci_clk, mem_clk;
   logic [1:0]  fs_latched;
   logic [7:0]  regs [6];
   logic [7:0]  wdata [7];
   logic [18:0] run;
   int          fails = 0;
   int          samples_checked = 0;
   int          hi_len = 0;
   link_pins_t  link_w;
   assign link_w = {scl, sda_wire};
   always #20 clk_in = ~clk_in;
   always @(negedge clk_in) src_cnt <= src_cnt + 4'h1;
   // the device pulls only where its data value is low and enabled
   two_wire_host host (.clk_in(clk_in), .dev_pull_in(sda_oe & ~sda_val), .scl_out(scl),
                       .sda_out(sda_wire));
   clock_output_enable_regs DUT (
      .clk_in(clk_in), .rst_b_in(rst_b), .link_in(link_w), .sda_out(sda_val), .sda_oe_out(sda_oe),
      .src_in(clk_src_t'({4{src_cnt[2]}})), .freq_select_pin_in(fs_pins),
      .pci_clock_out(pci_clk), .mem_clock_out(mem_clk), .mem_free_clock_out(free_clk),
      .dot_clock_out(dot_clk), .usb_clock_out(usb_clk), .spread_on_out(spread_on),
      .fs_latched_out(fs_latched));
   // a stopped or restarted pci clock must never show a short high pulse
   always @(posedge clk_in) begin
      if (!rst_b) begin
         hi_len <= 0;
      end else if (pci_clk[0] === 1'b1) begin
         hi_len <= hi_len + 1;
      end else begin
         if (hi_len != 0) `CHECK_EQ(hi_len, 4, "pci0 high width")
         hi_len <= 0;
      end
   end
   // ----------------------------------------------------------------
   // transfers
   // ----------------------------------------------------------------
   task do_write(input int n);
      logic ack;
      host.start_cond();
      host.wr_byte(8'hd2, ack);
      `CHECK_EQ(ack, 1'b1, "write address ack")
      host.wr_byte(8'h5e, ack);
      `CHECK_EQ(ack, 1'b1, "command ack")
      host.wr_byte(8'h81, ack);
      `CHECK_EQ(ack, 1'b1, "count ack")
      for (int i = 0; i < n; i++) begin
         host.wr_byte(wdata[i], ack);
         `CHECK_EQ(ack, 1'b1, "data ack")
         if (i < 6) regs[i] = wdata[i];
      end
      host.stop_cond();
   endtask : do_write
   task do_read;
      logic       ack;
      logic [7:0] b;
      host.start_cond();
      host.wr_byte(8'hd3, ack);
      `CHECK_EQ(ack, 1'b1, "read address ack")
      host.rd_byte(b, 1'b1);
      `CHECK_EQ(b, 8'h06, "byte count")
      for (int i = 0; i < 6; i++) begin
         host.rd_byte(b, 1'b1);
         `CHECK_EQ(b, (i == 3) ? regs[i] ^ 8'h70 : regs[i], "read back")
      end
      // nothing lies past byte 5: the line stays released
      host.rd_byte(b, 1'b1);
      `CHECK_EQ(b, 8'hff, "past last byte")
      host.stop_cond();
   endtask : do_read
   task check_outputs;
      logic [18:0] hi, lo, v;
      hi = '0;
      lo = '0;
      // settle first: enables only move in the low phase
      repeat (16) @(negedge clk_in);
      repeat (32) begin
         @(negedge clk_in);
         v = {pci_clk, mem_clk, dot_clk, usb_clk, free_clk};
         hi = hi | v;
         lo = lo | ~v;
      end
      run = hi & lo;
      `CHECK_EQ(run, {regs[2], regs[1], regs[0][2], regs[0][1], 1'b1}, "gating")
      `CHECK_EQ(hi & ~lo, 19'h0, "stopped output held low")
      `CHECK_EQ(spread_on, ~regs[0][3], "spread control")
   endtask : check_outputs
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_defaults;
      regs = '{8'h07, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      `CHECK_EQ(fs_latched, 2'b10, "latched selects")
      do_read();
      check_outputs();
      fs_pins = 2'b10;
      repeat (4) @(negedge clk_in);
      `CHECK_EQ(fs_latched, 2'b10, "selects hold after power-up")
   endtask : t_defaults
   task t_write_all;
      // seventh data byte is past the bank and must be dropped
      wdata = '{8'h0c, 8'h00, 8'hfe, 8'h5a, 8'ha5, 8'h3c, 8'h99};
      do_write(7);
      do_read();
      check_outputs();
   endtask : t_write_all
   task t_partial;
      wdata[0] = 8'hf2;
      wdata[1] = 8'h0f;
      do_write(2);
      do_read();
      check_outputs();
   endtask : t_partial
   task t_bad_addr;
      logic ack;
      host.start_cond();
      host.wr_byte(8'ha0, ack);
      `CHECK_EQ(ack, 1'b0, "foreign address refused")
      host.wr_byte(8'h00, ack);
      `CHECK_EQ(ack, 1'b0, "no ack after refusal")
      host.stop_cond();
      do_read();
   endtask : t_bad_addr
   task t_slow;
      host.half_cycles = 84;
      wdata[0] = 8'h07;
      wdata[1] = 8'hff;
      wdata[2] = 8'hff;
      do_write(3);
      host.half_cycles = 4;
      do_read();
      check_outputs();
   endtask : t_slow
   task close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (80000) @(posedge clk_in);
      fails++;
      close_out();
   end
   initial begin
      repeat (20) @(negedge clk_in);
      rst_b = 1'b1;
      repeat (2) @(negedge clk_in);
      t_defaults();
      t_write_all();
      t_partial();
      t_bad_addr();
      t_slow();
      close_out();
   end
endmodule : clock_output_enable_regs_test
